// ===== shared/ebiu_pkg.sv
package ebiu_pkg;
   localparam int unsigned ADDR_W        = 20;
   localparam int unsigned DATA_W        = 16;
   localparam int unsigned NUM_PCS       = 8;
   localparam int unsigned NUM_MEM_SEL   = 6;
   localparam int unsigned WS_W          = 4;
   localparam logic [15:0] PCB_RESET_BASE = 16'hfc00;
   localparam int unsigned PCB_SIZE_BYTES = 1024;
   localparam int unsigned PCB_IDX_W     = 9;
   localparam int unsigned PCS_BLOCK_BYTES = 256;
   localparam int unsigned PCS_OFS_W     = 8;
   localparam logic [WS_W-1:0] REFRESH_WAIT = 4'h3;
   localparam int unsigned DRAM_BANK_WORDS_LOG2 = 18;
   localparam int unsigned DRAM_ROWCOL_W = 9;
   localparam int unsigned UMS_IDX       = 0;
   localparam int unsigned LMS_IDX       = 1;
   typedef enum logic [1:0] {
      PH_T1,
      PH_T2,
      PH_T3,
      PH_T4
   } phase_e;
endpackage

// ===== core/pcb_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module pcb_regfile (
   input  wire logic                             clk_i,
   input  wire logic                             sys_rst_i,
   input  wire logic                             wr_i,
   input  wire logic                             rd_i,
   input  wire logic [ebiu_pkg::PCB_IDX_W-1:0]   idx_i,
   input  wire logic [ebiu_pkg::DATA_W-1:0]      wdata_i,
   output logic      [ebiu_pkg::DATA_W-1:0]      rdata_o
);
   import ebiu_pkg::*;
   localparam int unsigned DEPTH = PCB_SIZE_BYTES / 2;
   logic [DATA_W-1:0] mem [DEPTH];
   // 16-bit read/write storage for the control block
   always_ff @(posedge clk_i) begin
      if (wr_i) begin
         mem[idx_i] <= wdata_i;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= '0;
      end else if (rd_i) begin
         rdata_o <= mem[idx_i];
      end
   end
endmodule
`default_nettype wire

// ===== core/chipsel_decode.sv
`timescale 1ns/1ps
`default_nettype none
module chipsel_decode (
   input  wire logic [ebiu_pkg::ADDR_W-1:0]       addr_i,
   input  wire logic                              io_i,
   input  wire logic [ebiu_pkg::NUM_PCS-1:0]      pcs_en_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]       pcs_base_i,
   input  wire logic                              pcs_mem_i,
   output logic      [ebiu_pkg::NUM_PCS-1:0]      pcs_hit_o
);
   import ebiu_pkg::*;
   localparam int unsigned BLK_W = ADDR_W - PCS_OFS_W;
   // eight consecutive 256-byte blocks from one base
   for (genvar g = 0; g < NUM_PCS; g++) begin : g_pcs
      logic [BLK_W-1:0] blk;
      assign blk = pcs_base_i[ADDR_W-1:PCS_OFS_W] + BLK_W'(g);
      assign pcs_hit_o[g] = pcs_en_i[g] && (io_i != pcs_mem_i)
                            && (addr_i[ADDR_W-1:PCS_OFS_W] == blk);
   end
endmodule
`default_nettype wire

// ===== core/ext_bus_unit.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_unit (
   input  wire logic                           clk_i,
   input  wire logic                           sys_rst_i,
   input  wire logic                           addr_force_pin_n_i,
   input  wire logic                           req_i,
   input  wire logic                           req_dma_i,
   input  wire logic                           req_write_i,
   input  wire logic                           req_io_i,
   input  wire logic                           req_byte_high_i,
   input  wire logic                           req_refresh_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    req_addr_i,
   input  wire logic [ebiu_pkg::DATA_W-1:0]    req_wdata_i,
   input  wire logic                           ext_ready_i,
   input  wire logic                           hold_i,
   input  wire logic [ebiu_pkg::DATA_W-1:0]    ad_i,
   input  wire logic                           upper_mem_select_reg_wr_i,
   input  wire logic                           upper_addr_disable_bit_i,
   input  wire logic                           upper_use_ready_i,
   input  wire logic [ebiu_pkg::WS_W-1:0]      upper_wait_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    upper_start_i,
   input  wire logic                           lower_mem_select_reg_wr_i,
   input  wire logic                           lower_addr_disable_bit_i,
   input  wire logic                           lower_use_ready_i,
   input  wire logic [ebiu_pkg::WS_W-1:0]      lower_wait_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    lower_end_i,
   input  wire logic                           lower_is_dram_i,
   input  wire logic                           mid_reg_wr_i,
   input  wire logic                           mid_use_ready_i,
   input  wire logic [ebiu_pkg::WS_W-1:0]      mid_wait_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    mid_base_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    mid_size_i,
   input  wire logic                           mid_is_dram_i,
   input  wire logic                           pcs_reg_wr_i,
   input  wire logic                           pcs_use_ready_i,
   input  wire logic [ebiu_pkg::WS_W-1:0]      pcs_wait_i,
   input  wire logic [ebiu_pkg::ADDR_W-1:0]    pcs_base_i,
   input  wire logic                           pcs_mem_i,
   input  wire logic                           pcb_relocate_i,
   input  wire logic [15:0]                    pcb_new_base_i,
   output logic                                done_o,
   output logic      [ebiu_pkg::DATA_W-1:0]    rdata_o,
   output logic                                system_clock_out_o,
   output logic      [ebiu_pkg::ADDR_W-1:0]    flat_addr_bus_o,
   output logic      [ebiu_pkg::DATA_W-1:0]    ad_o,
   output logic                                ad_oe_o,
   output logic                                rd_n_o,
   output logic                                write_high_byte_n_o,
   output logic                                write_low_byte_n_o,
   output logic                                byte_high_enable_n_o,
   output logic                                upper_mem_select_n_o,
   output logic                                lower_mem_select_n_o,
   output logic                                mid_mem_select_one_n_o,
   output logic                                mid_mem_select_two_n_o,
   output logic                                mid_mem_select_three_n_o,
   output logic                                mid_mem_select_zero_n_o,
   output logic      [ebiu_pkg::NUM_PCS-1:0]   periph_select_n_o,
   output logic                                cs_oe_o,
   output logic                                addr_disable_active_o
);
   import ebiu_pkg::*;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_T1A,
      ST_T1B,
      ST_T2,
      ST_T3,
      ST_TW,
      ST_T4
   } bus_state_e;
   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser and force strap
   logic [2:0] force_sync;
   logic       force_latched;
   logic       in_reset_q;
   // no reset: keeps sampling the strap pin while reset is held
   always_ff @(posedge clk_i) begin
      force_sync <= {force_sync[1:0], ~addr_force_pin_n_i};
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         in_reset_q    <= 1'b1;
         force_latched <= 1'b0;
      end else if (in_reset_q) begin
         in_reset_q    <= 1'b0;
         force_latched <= force_sync[1] & force_sync[2];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // select enables, set only by register writes
   logic up_en;
   logic lo_en;
   logic mid_en;
   logic pcs_en;
   logic up_adis;
   logic lo_adis;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         up_en  <= 1'b0;
         lo_en  <= 1'b0;
         mid_en <= 1'b0;
         pcs_en <= 1'b0;
         up_adis <= 1'b0;
         lo_adis <= 1'b0;
      end else begin
         if (upper_mem_select_reg_wr_i) begin
            up_en <= 1'b1;
            up_adis <= upper_addr_disable_bit_i;
         end
         if (lower_mem_select_reg_wr_i) begin
            lo_en <= 1'b1;
            lo_adis <= lower_addr_disable_bit_i;
         end
         if (mid_reg_wr_i) begin
            mid_en <= 1'b1;
         end
         if (pcs_reg_wr_i) begin
            pcs_en <= 1'b1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // control block base
   logic [15:0] pcb_base;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pcb_base <= PCB_RESET_BASE;
      end else if (pcb_relocate_i) begin
         pcb_base <= pcb_new_base_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // address decode
   logic [NUM_PCS-1:0] pcs_hit;
   logic               hit_pcb;
   logic               hit_up;
   logic               hit_lo;
   logic               hit_mid;
   logic               dram_cyc;
   logic               use_rdy;
   logic [WS_W-1:0]    waits;
   logic [ADDR_W-1:0]  mid_off;
   chipsel_decode u_dec (
      .addr_i     (req_addr_i),
      .io_i       (req_io_i),
      .pcs_en_i   ({NUM_PCS{pcs_en}}),
      .pcs_base_i (pcs_base_i),
      .pcs_mem_i  (pcs_mem_i),
      .pcs_hit_o  (pcs_hit)
   );
   assign mid_off = req_addr_i - mid_base_i;
   // memory decode ignores who started the cycle; control block decode excludes DMA cycles
   always_comb begin
      hit_pcb  = req_io_i && !req_dma_i
                 && (req_addr_i[15:10] == pcb_base[15:10]);
      hit_up   = !req_io_i && up_en && (req_addr_i >= upper_start_i);
      hit_lo   = !req_io_i && lo_en && (req_addr_i <= lower_end_i) && !hit_up;
      hit_mid  = !req_io_i && mid_en && !hit_up && !hit_lo
                 && (mid_off < mid_size_i);
      dram_cyc = ((hit_lo && lower_is_dram_i) || (hit_mid && mid_is_dram_i))
                 && !(|pcs_hit);
      use_rdy  = 1'b0;
      waits    = '0;
      if (req_refresh_i) begin
         waits = REFRESH_WAIT;
      end else if (|pcs_hit) begin
         use_rdy = pcs_use_ready_i;
         waits   = pcs_wait_i;
      end else if (hit_up) begin
         use_rdy = upper_use_ready_i;
         waits   = upper_wait_i;
      end else if (hit_lo) begin
         use_rdy = lower_use_ready_i;
         waits   = lower_wait_i;
      end else if (hit_mid) begin
         use_rdy = mid_use_ready_i;
         waits   = mid_wait_i;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // control block storage
   logic [DATA_W-1:0] pcb_rdata;
   logic              pcb_wr;
   logic              pcb_rd;
   logic              c_pcb;
   logic              c_write;
   logic [ADDR_W-1:0] c_addr;
   logic [DATA_W-1:0] c_wdata;
   bus_state_e        state;
   assign pcb_wr = c_pcb && c_write && (state == ST_T2);
   assign pcb_rd = c_pcb && !c_write && (state == ST_T2);
   pcb_regfile u_pcb (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .wr_i      (pcb_wr),
      .rd_i      (pcb_rd),
      .idx_i     (c_addr[PCB_IDX_W:1]),
      .wdata_i   (c_wdata),
      .rdata_o   (pcb_rdata)
   );
   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer, one clk per output clock phase
   logic              c_refresh;
   logic              c_rdy;
   logic              c_bhe;
   logic              c_dram;
   logic              c_adis;
   logic [WS_W-1:0]   wcnt;
   logic [NUM_PCS-1:0] c_pcs;
   logic              c_up;
   logic              c_lo;
   logic              c_mid;
   logic              half;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         half <= 1'b0;
      end else begin
         half <= ~half;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state <= ST_IDLE;
         wcnt  <= '0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (req_i && !hold_i) begin
                  state <= ST_T1A;
                  wcnt  <= waits;
               end
            end
            ST_T1A: state <= ST_T1B;
            ST_T1B: state <= ST_T2;
            ST_T2:  state <= ST_T3;
            ST_T3: begin
               if (wcnt != '0) begin
                  state <= ST_TW;
                  wcnt  <= wcnt - 1'b1;
               end else if (c_rdy && !ext_ready_i) begin
                  state <= ST_TW;
               end else begin
                  state <= ST_T4;
               end
            end
            ST_TW: begin
               if (wcnt != '0) begin
                  wcnt <= wcnt - 1'b1;
               end else if (!c_rdy || ext_ready_i) begin
                  state <= ST_T4;
               end
            end
            ST_T4: state <= ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         c_refresh <= 1'b0;
         c_rdy     <= 1'b0;
         c_write   <= 1'b0;
         c_bhe     <= 1'b0;
         c_dram    <= 1'b0;
         c_adis    <= 1'b0;
         c_pcb     <= 1'b0;
         c_addr    <= '0;
         c_wdata   <= '0;
         c_pcs     <= '0;
         c_up      <= 1'b0;
         c_lo      <= 1'b0;
         c_mid     <= 1'b0;
      end else if (state == ST_IDLE && req_i && !hold_i) begin
         c_refresh <= req_refresh_i;
         c_rdy     <= use_rdy;
         c_write   <= req_write_i;
         c_bhe     <= req_byte_high_i;
         c_dram    <= dram_cyc && !req_refresh_i;
         c_adis    <= !force_latched
                      && ((hit_up && up_adis) || (hit_lo && lo_adis));
         c_pcb     <= hit_pcb && !req_refresh_i;
         c_addr    <= req_addr_i;
         c_wdata   <= req_wdata_i;
         c_pcs     <= pcs_hit;
         c_up      <= hit_up && !(|pcs_hit);
         c_lo      <= hit_lo && !(|pcs_hit) && !dram_cyc && !req_refresh_i;
         c_mid     <= hit_mid && !(|pcs_hit) && !dram_cyc;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // pin drivers, all registered
   logic active;
   logic t1;
   logic late;
   assign active = (state != ST_IDLE);
   assign t1     = (state == ST_T1A) || (state == ST_T1B);
   assign late   = (state == ST_T2) || (state == ST_T3) || (state == ST_TW);
   logic [ADDR_W-1:0] dram_row;
   logic [ADDR_W-1:0] dram_col;
   always_comb begin
      dram_row = '0;
      dram_col = '0;
      for (int b = 0; b < DRAM_ROWCOL_W; b++) begin
         dram_row[2*b+1] = c_addr[b + DRAM_ROWCOL_W + 1];
         dram_col[2*b+1] = c_addr[b + 1];
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         system_clock_out_o <= 1'b0;
      end else begin
         system_clock_out_o <= half;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flat_addr_bus_o <= '0;
      end else if (state == ST_IDLE && req_i && !hold_i) begin
         flat_addr_bus_o <= dram_cyc ? '0 : req_addr_i;
      end else if (c_dram && state == ST_T2) begin
         flat_addr_bus_o <= dram_col;
      end else if (c_dram && state == ST_T1A) begin
         flat_addr_bus_o <= dram_row;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ad_o    <= '0;
         ad_oe_o <= 1'b0;
      end else begin
         ad_oe_o <= 1'b0;
         if (state == ST_T1A) begin
            ad_o    <= c_addr[DATA_W-1:0];
            ad_oe_o <= !c_adis;
         end else if (state == ST_T1B) begin
            ad_oe_o <= !c_adis;
         end else if (late && c_write && !c_refresh) begin
            ad_o    <= c_wdata;
            ad_oe_o <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rd_n_o               <= 1'b1;
         write_high_byte_n_o  <= 1'b1;
         write_low_byte_n_o   <= 1'b1;
         byte_high_enable_n_o <= 1'b1;
      end else begin
         rd_n_o               <= !(late && !c_write && !c_refresh);
         byte_high_enable_n_o <= !(active && c_bhe);
         write_high_byte_n_o  <= !(c_bhe && late && c_write && !c_refresh);
         write_low_byte_n_o   <= !(!c_addr[0] && late && c_write && !c_refresh);
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         upper_mem_select_n_o     <= 1'b1;
         lower_mem_select_n_o     <= 1'b1;
         mid_mem_select_zero_n_o  <= 1'b1;
         mid_mem_select_one_n_o   <= 1'b1;
         mid_mem_select_two_n_o   <= 1'b1;
         mid_mem_select_three_n_o <= 1'b1;
         periph_select_n_o        <= '1;
         cs_oe_o                  <= 1'b0;
         addr_disable_active_o    <= 1'b0;
         done_o                   <= 1'b0;
         rdata_o                  <= '0;
      end else begin
         cs_oe_o               <= !hold_i || active;
         addr_disable_active_o <= active && c_adis;
         upper_mem_select_n_o  <= !(active && c_up && !c_refresh);
         periph_select_n_o     <= ~(c_pcs & {NUM_PCS{active && !c_refresh}});
         mid_mem_select_zero_n_o <= !(active && c_mid && !c_refresh);
         // RAS on lower select or mid three, CAS on mid two and one
         lower_mem_select_n_o  <= !(active && (c_lo || (c_dram && c_addr[ADDR_W-1] == 1'b0)
                                  || (c_refresh && late)));
         mid_mem_select_three_n_o <= !((active && c_dram && c_addr[ADDR_W-1])
                                     || (c_refresh && late));
         mid_mem_select_two_n_o <= !((c_dram && late && c_bhe)
                                   || (c_refresh && active));
         mid_mem_select_one_n_o <= !((c_dram && late && !c_addr[0])
                                   || (c_refresh && active));
         done_o <= (state == ST_T4);
         if (state == ST_T4 && !c_write) begin
            rdata_o <= c_pcb ? pcb_rdata : ad_i;
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/ebu_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ebu_chk (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic req_i,
   input wire logic hold_i,
   input wire logic req_write_i,
   input wire logic req_refresh_i,
   input wire logic lower_is_dram_i,
   input wire logic [ebiu_pkg::ADDR_W-1:0] req_addr_i,
   input wire logic done_o,
   input wire logic rd_n_o,
   input wire logic write_high_byte_n_o,
   input wire logic write_low_byte_n_o,
   input wire logic byte_high_enable_n_o,
   input wire logic cs_oe_o,
   input wire logic [ebiu_pkg::ADDR_W-1:0] flat_addr_bus_o
);
   import ebiu_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   logic busy;
   logic [ADDR_W-1:0] tka;
   wire tk = req_i && !hold_i && !busy;
   wire stb = !rd_n_o || !write_low_byte_n_o || !write_high_byte_n_o;
   ////////////////////////////////////////////////
   // cycle tracking
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) busy <= 1'h0;
      else if (tk) busy <= 1'h1;
      else if (done_o) busy <= 1'h0;
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) tka <= '0;
      else if (tk) tka <= req_addr_i;
   end
   ////////////////////////////////////////////////
   property p_hi_we; !write_high_byte_n_o |-> !byte_high_enable_n_o; endproperty
   a_hi_we: assert property (p_hi_we)
      else $error("high write enable without byte-high enable");
   property p_lo_we; !write_low_byte_n_o |-> !flat_addr_bus_o[0]; endproperty
   a_lo_we: assert property (p_lo_we)
      else $error("low write enable with odd address");
   property p_stb; !rd_n_o |-> write_high_byte_n_o && write_low_byte_n_o; endproperty
   a_stb: assert property (p_stb)
      else $error("read and write together");
   property p_adr; stb && !lower_is_dram_i |-> flat_addr_bus_o == tka; endproperty
   a_adr: assert property (p_adr)
      else $error("flat address wrong in strobe");
   property p_fla; stb && $past(stb) |-> $stable(flat_addr_bus_o); endproperty
   a_fla: assert property (p_fla)
      else $error("flat address moved");
   property p_rd; tk && !req_write_i && !req_refresh_i |-> ##[2:4] !rd_n_o; endproperty
   a_rd: assert property (p_rd)
      else $error("no read strobe");
   property p_ans; tk |-> ##[6:90] done_o; endproperty
   a_ans: assert property (p_ans)
      else $error("no done");
   property p_ref; tk && req_refresh_i |=> !done_o [*8]; endproperty
   a_ref: assert property (p_ref)
      else $error("refresh too short");
   property p_one; done_o |=> !done_o; endproperty
   a_one: assert property (p_one)
      else $error("done twice");
   property p_cs; (hold_i && !busy) [*4] |-> !cs_oe_o; endproperty
   a_cs: assert property (p_cs)
      else $error("selects driven in hold");
   c_wr: cover property (tk && req_write_i);
   c_rf: cover property (tk && req_refresh_i);
   c_hd: cover property (hold_i && !busy);
endmodule
bind ext_bus_unit ebu_chk u_chk (.*);
`default_nettype wire

// ===== dv/ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [19:0] addr_i,
   output logic [15:0] ad_o,
   output logic ready_o
);
   logic [15:0] last = 16'h0;
   logic [2:0] cnt;
   always_ff @(posedge clk_i) begin
      if (rd_n_i && wr_n_i) cnt <= 3'h0;
      else if (cnt != 3'h7) cnt <= cnt + 3'h1;
      if (!rd_n_i) last <= ad_o;
   end
   // slow mode holds ready low two cycles
   assign ready_o = !slow_i || cnt >= 3'h2;
   // released bus shows inverse of last data
   assign ad_o = rd_n_i ? ~last : addr_i[15:0] ^ 16'h5a5a;
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ebiu_pkg::*;
   logic clk_i = 1'h0;
   logic sys_rst_i, addr_force_pin_n_i, req_i, req_dma_i, req_write_i, req_io_i;
   logic req_byte_high_i, req_refresh_i, hold_i, upper_mem_select_reg_wr_i;
   logic upper_addr_disable_bit_i, upper_use_ready_i, lower_mem_select_reg_wr_i;
   logic lower_addr_disable_bit_i, lower_use_ready_i, lower_is_dram_i, mid_reg_wr_i;
   logic mid_use_ready_i, mid_is_dram_i, pcs_reg_wr_i, pcs_use_ready_i, pcs_mem_i;
   logic pcb_relocate_i, done_o, system_clock_out_o, ad_oe_o, rd_n_o, cs_oe_o, slow;
   logic write_high_byte_n_o, write_low_byte_n_o, byte_high_enable_n_o;
   logic upper_mem_select_n_o, lower_mem_select_n_o, addr_disable_active_o;
   logic mid_mem_select_one_n_o, mid_mem_select_two_n_o;
   logic mid_mem_select_three_n_o, mid_mem_select_zero_n_o;
   logic [ADDR_W-1:0] req_addr_i, upper_start_i, lower_end_i, mid_base_i, a;
   logic [ADDR_W-1:0] mid_size_i, pcs_base_i, flat_addr_bus_o;
   logic [DATA_W-1:0] req_wdata_i, rdata_o, ad_o, pcb_new_base_i;
   logic [WS_W-1:0] upper_wait_i, lower_wait_i, mid_wait_i, pcs_wait_i;
   logic [7:0] periph_select_n_o;
   logic [5:0] seen;
   wire [DATA_W-1:0] ad_i;
   wire ext_ready_i;
   int n, oe, dis, base, err_count, total_checks;
   int seed = 80436;
   logic [19:0] ra[4] = '{20'hc4321, 20'h01234, 20'h80010, 20'h90100};
   int wt[4] = '{1, 2, 3, 5};
   always #2.5 clk_i = ~clk_i;
   ext_bus_unit dut (.*);
   ext_mem_model mem (.clk_i(clk_i), .slow_i(slow), .rd_n_i(rd_n_o),
      .wr_n_i(write_high_byte_n_o & write_low_byte_n_o), .addr_i(flat_addr_bus_o),
      .ad_o(ad_i), .ready_o(ext_ready_i));
   ////////////////////////////////////////////////
   task test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input logic [31:0] e, input logic [31:0] s, input string nm);
      total_checks++;
      if (e !== s) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", nm, e, s);
      end
   endtask
   task cfg(input logic d);
      lower_addr_disable_bit_i <= d;
      {upper_mem_select_reg_wr_i, lower_mem_select_reg_wr_i, mid_reg_wr_i, pcs_reg_wr_i} <= 4'hf;
      @(posedge clk_i);
      {upper_mem_select_reg_wr_i, lower_mem_select_reg_wr_i, mid_reg_wr_i, pcs_reg_wr_i} <= 4'h0;
      @(posedge clk_i);
   endtask
   task cyc(input logic w, input logic [19:0] ad, input logic r);
      req_write_i <= w;
      req_addr_i <= ad;
      req_refresh_i <= r;
      req_wdata_i <= 16'($random(seed));
      req_i <= 1'h1;
      @(posedge clk_i);
      req_i <= 1'h0;
      n = 0;
      oe = 0;
      dis = 0;
      seen = '0;
      do begin
         @(posedge clk_i);
         n++;
         oe += int'(ad_oe_o);
         dis += int'(addr_disable_active_o);
         seen |= ~{write_high_byte_n_o, write_low_byte_n_o, &periph_select_n_o,
            &{mid_mem_select_zero_n_o, mid_mem_select_one_n_o, mid_mem_select_two_n_o,
            mid_mem_select_three_n_o}, lower_mem_select_n_o, upper_mem_select_n_o};
      end while (done_o !== 1'h1 && n < 99);
      if (n >= 99) begin
         err_count++;
         test_done();
      end
      @(posedge clk_i);
   endtask
   ////////////////////////////////////////////////
   initial begin
      {req_i, req_dma_i, req_write_i, req_io_i, req_refresh_i, hold_i, slow, upper_wait_i,
         lower_wait_i, mid_wait_i, pcs_wait_i, upper_addr_disable_bit_i, upper_use_ready_i,
         lower_addr_disable_bit_i, lower_use_ready_i, lower_is_dram_i, mid_use_ready_i,
         mid_is_dram_i, pcs_use_ready_i, pcb_relocate_i, req_addr_i, req_wdata_i} = '0;
      {upper_mem_select_reg_wr_i, lower_mem_select_reg_wr_i, mid_reg_wr_i, pcs_reg_wr_i} = '0;
      {sys_rst_i, addr_force_pin_n_i, req_byte_high_i, pcs_mem_i} = 4'hf;
      {upper_start_i, lower_end_i, mid_base_i} = {20'hc0000, 20'h3ffff, 20'h80000};
      {mid_size_i, pcs_base_i, pcb_new_base_i} = {20'h10000, 20'h90000, 16'hfc00};
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      @(posedge clk_i);
      chk(0, addr_disable_active_o, "disable at reset");
      cfg(1'h0);
      cyc(1'h0, 20'h01234, 1'h0);
      base = n;
      chk(1, oe > 0, "address on ad");
      {upper_wait_i, lower_wait_i, mid_wait_i, pcs_wait_i} <= {4'h1, 4'h2, 4'h3, 4'h5};
      for (int i = 0; i < 4; i++) begin
         req_dma_i <= i[0];
         cyc(1'h0, ra[i], 1'h0);
         chk(base + wt[i], n, "wait states");
         chk(1 << i, seen[3:0], "select");
         chk(ra[i][15:0] ^ 16'h5a5a, rdata_o, "rdata");
      end
      req_dma_i <= 1'h0;
      repeat (6) begin
         a = 20'($random(seed)) & 20'h3fffe;
         cyc(1'h0, a, 1'h0);
         chk(a[15:0] ^ 16'h5a5a, rdata_o, "random rdata");
      end
      $display("test reads done");
      for (int k = 0; k < 3; k++) begin
         req_byte_high_i <= k != 2;
         cyc(1'h1, 20'h00100 | 20'(k[0]), 1'h0);
         chk({k != 2, k != 1}, seen[5:4], "write enables");
      end
      req_byte_high_i <= 1'h1;
      lower_use_ready_i <= 1'h1;
      slow <= 1'h1;
      lower_wait_i <= 4'h0;
      cyc(1'h0, 20'h01234, 1'h0);
      chk(base + 2, n, "ready waited");
      lower_use_ready_i <= 1'h0;
      cyc(1'h0, 20'h01234, 1'h0);
      chk(base, n, "ready ignored");
      slow <= 1'h0;
      cyc(1'h0, 20'h00000, 1'h1);
      chk(base + 3, n, "refresh length");
      req_io_i <= 1'h1;
      cyc(1'h1, 20'h0fc10, 1'h0);
      a = 20'(req_wdata_i);
      cyc(1'h0, 20'h0fc10, 1'h0);
      chk(a[15:0], rdata_o, "control block");
      req_io_i <= 1'h0;
      lower_is_dram_i <= 1'h1;
      cyc(1'h0, 20'h01234, 1'h0);
      chk(6, seen[3:0], "dram strobes");
      lower_is_dram_i <= 1'h0;
      $display("test timing done");
      hold_i <= 1'h1;
      req_i <= 1'h1;
      repeat (4) @(posedge clk_i);
      n = 0;
      repeat (20) begin
         @(posedge clk_i);
         n += int'(done_o) + int'(cs_oe_o);
      end
      chk(0, n, "hold");
      req_i <= 1'h0;
      @(posedge clk_i);
      hold_i <= 1'h0;
      cfg(1'h1);
      cyc(1'h0, 20'h01234, 1'h0);
      chk(1, dis > 0, "disable on");
      chk(0, oe, "address off");
      sys_rst_i <= 1'h1;
      addr_force_pin_n_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      sys_rst_i <= 1'h0;
      repeat (2) @(posedge clk_i);
      cfg(1'h1);
      cyc(1'h0, 20'h01234, 1'h0);
      chk(0, dis, "forced");
      chk(1, oe > 0, "forced address");
      $display("test disable done");
      test_done();
   end
endmodule
`default_nettype wire
